// >>> src/runtime_disable_gpio_regs.sv
// Runtime register slice: serial FIFO shadow, block disable override, joystick pin
module runtime_disable_gpio_regs
    import rt_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [rt_regs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rt_regs_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [rt_regs_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Serial port two FIFO control write
    input  wire logic                          fifo_ctrl_wr,
    input  wire logic [rt_regs_pkg::REG_W-1:0]  fifo_ctrl_data,
    // Activate bits of each block
    input  wire logic                          floppy_activate,
    input  wire logic                          midi_activate,
    input  wire logic                          serial_two_activate,
    input  wire logic                          serial_one_activate,
    input  wire logic                          parallel_activate,
    // Resulting block enables
    output logic                               floppy_enable,
    output logic                               midi_enable,
    output logic                               serial_two_enable,
    output logic                               serial_one_enable,
    output logic                               parallel_enable,
    // Floppy write protection
    input  wire logic                          drive_select_zero_n,
    input  wire logic                          drive_select_one_n,
    input  wire logic                          media_protect_n,
    input  wire logic                          forced_protect,
    output logic                               core_media_protect,
    // Lock pin
    input  wire logic [1:0]                    disable_lock_pin_cfg,
    input  wire logic                          disable_lock_pin,
    output logic                               disable_locked,
    // Joystick button pin
    input  wire logic                          gpio_out_data,
    output logic                               gpio_in_data,
    output logic                               joystick_one_button_one,
    input  wire logic                          pin_pad_in,
    output logic                               pin_pad_out,
    output logic                               pin_pad_oe
);
    import rt_regs_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    apb_state_t         state_r;
    apb_state_t         state_nxt;
    logic [REG_W-1:0]   fifo_shadow_r;
    logic [REG_W-1:0]   disable_r;
    logic [REG_W-1:0]   pin_cfg_r;
    logic [DATA_W-1:0]  prdata_r;
    logic               err_r;
    logic               err_nxt;
    logic [REG_W-1:0]   rd_byte;
    logic               hit_shadow;
    logic               hit_disable;
    logic               hit_pin;
    logic               hit_any;
    logic               lock_now;
    logic               setup_phase;
    logic               wr_commit;
    logic               wr_lane0;
    logic [N_BLOCKS-1:0] activate_vec;
    logic [N_BLOCKS-1:0] enable_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Full word compare; any other address is unmapped
    assign hit_shadow  = (paddr == ADDR_FIFO_SHADOW);
    assign hit_disable = (paddr == ADDR_DISABLE);
    assign hit_pin     = (paddr == ADDR_PIN_CFG);
    assign hit_any     = hit_shadow | hit_disable | hit_pin;

    // Setup phase and committed write
    assign setup_phase = psel & ~penable;
    assign wr_commit   = psel & penable & pready & pwrite;
    // Registers hold eight bits, so only lane 0 carries data
    assign wr_lane0    = pstrb[0];

    // ------------------------------------------------------------
    // Lock condition
    // ------------------------------------------------------------
    // lock armed by config code and high pin
    assign lock_now = (disable_lock_pin_cfg == LOCK_CFG_CODE) & disable_lock_pin;

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    // One wait-free access cycle after each setup cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (setup_phase) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (setup_phase) begin
                    state_nxt = ST_ACCESS;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Ready in the access phase that follows a taken setup
    assign pready  = (state_r == ST_ACCESS) & psel & penable;
    assign pslverr = pready & err_r;

    // ------------------------------------------------------------
    // Read data mux and error decision
    // ------------------------------------------------------------
    // Masks zero reserved bits on the way out
    always_comb begin
        rd_byte = 8'h00;
        err_nxt = 1'b0;
        if (hit_shadow) begin
            rd_byte = fifo_shadow_r & FS_MASK;
            // writes to the shadow are refused
            err_nxt = pwrite;
        end else if (hit_disable) begin
            rd_byte = disable_r & DD_MASK;
            err_nxt = pwrite & lock_now;
        end else if (hit_pin) begin
            rd_byte = pin_cfg_r & PC_MASK;
            err_nxt = 1'b0;
        end else begin
            rd_byte = 8'h00;
            err_nxt = 1'b1;
        end
    end

    // Read data and error captured at the setup edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end else if (setup_phase) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            err_r    <= err_nxt;
        end
    end

    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // Serial FIFO control shadow
    // ------------------------------------------------------------
    // capture each FIFO control write
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fifo_shadow_r <= RST_FIFO_SHADOW;
        end else if (fifo_ctrl_wr) begin
            fifo_shadow_r <= fifo_ctrl_data & FS_MASK;
        end
    end

    // ------------------------------------------------------------
    // Block disable register
    // ------------------------------------------------------------
    // write only when the lock is not armed
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            disable_r <= RST_DISABLE;
        end else if (wr_commit && hit_disable && wr_lane0 && !lock_now && !err_r) begin
            disable_r <= pwdata[REG_W-1:0] & DD_MASK;
        end
    end

    // Lock status for software and system
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            disable_locked <= 1'b0;
        end else begin
            disable_locked <= lock_now;
        end
    end

    // ------------------------------------------------------------
    // Joystick pin configuration register
    // ------------------------------------------------------------
    // Reserved bits 6:3 are not stored
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_cfg_r <= RST_PIN_CFG;
        end else if (wr_commit && hit_pin && wr_lane0) begin
            pin_cfg_r <= pwdata[REG_W-1:0] & PC_MASK;
        end
    end

    // ------------------------------------------------------------
    // Block enables
    // ------------------------------------------------------------
    // Activate bits in disable-bit order, floppy first
    assign activate_vec = {parallel_activate,
                           serial_one_activate,
                           serial_two_activate,
                           midi_activate,
                           floppy_activate};

    // disable bit overrides the activate bit
    generate
        for (genvar gi = 0; gi < N_BLOCKS; gi++) begin : g_block
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    enable_r[gi] <= 1'b0;
                end else begin
                    enable_r[gi] <= activate_vec[gi] & ~disable_r[DD_FIRST + gi];
                end
            end
        end
    endgenerate

    assign floppy_enable     = enable_r[DD_FLOPPY - DD_FIRST];
    assign midi_enable       = enable_r[DD_MIDI - DD_FIRST];
    assign serial_two_enable = enable_r[DD_SERIAL2 - DD_FIRST];
    assign serial_one_enable = enable_r[DD_SERIAL1 - DD_FIRST];
    assign parallel_enable   = enable_r[DD_PARALLEL - DD_FIRST];

    // ------------------------------------------------------------
    // Floppy write protection
    // ------------------------------------------------------------
    // four-term OR to the floppy core
    // bit 0 forces protection on its own
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            core_media_protect <= 1'b0;
        end else begin
            core_media_protect <= (drive_select_zero_n & forced_protect)
                                | (drive_select_one_n & forced_protect)
                                | media_protect_n
                                | disable_r[DD_PROTECT];
        end
    end

    // ------------------------------------------------------------
    // Joystick button pin
    // ------------------------------------------------------------
    // pin cell follows the stored configuration
    joy_pin_cell joy_pin_cell_i (
        .ref_clk                 (ref_clk),
        .reset                   (reset),
        .pin_cfg                 (pin_cfg_r),
        .gpio_out_data           (gpio_out_data),
        .gpio_in_data            (gpio_in_data),
        .joystick_one_button_one (joystick_one_button_one),
        .pad_in                  (pin_pad_in),
        .pad_out                 (pin_pad_out),
        .pad_oe                  (pin_pad_oe)
    );

endmodule : runtime_disable_gpio_regs

// >>> src/rt_regs_pkg.sv
// Constants for the disable, serial FIFO shadow and joystick pin register slice
package rt_regs_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // ------------------------------------------------------------
    // Register indices and byte addresses (index times four)
    // ------------------------------------------------------------
    localparam logic [7:0]        IDX_FIFO_SHADOW  = 8'h21;
    localparam logic [7:0]        IDX_DISABLE      = 8'h22;
    localparam logic [7:0]        IDX_PIN_CFG      = 8'h23;
    localparam logic [ADDR_W-1:0] ADDR_FIFO_SHADOW = {2'b00, IDX_FIFO_SHADOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DISABLE     = {2'b00, IDX_DISABLE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PIN_CFG     = {2'b00, IDX_PIN_CFG, 2'b00};

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_FIFO_SHADOW = 8'h00;
    localparam logic [REG_W-1:0] RST_DISABLE     = 8'h00;
    localparam logic [REG_W-1:0] RST_PIN_CFG     = 8'h01;

    // ------------------------------------------------------------
    // Serial FIFO control shadow fields
    // ------------------------------------------------------------
    localparam int FS_FIFO_EN  = 0;
    localparam int FS_RX_RST   = 1;
    localparam int FS_TX_RST   = 2;
    localparam int FS_DMA_MODE = 3;
    localparam int FS_TRIG_LO  = 6;
    localparam int FS_TRIG_HI  = 7;
    localparam logic [REG_W-1:0] FS_MASK = 8'hCF;

    // ------------------------------------------------------------
    // Block disable fields
    // ------------------------------------------------------------
    localparam int DD_PROTECT  = 0;
    localparam int DD_FLOPPY   = 3;
    localparam int DD_MIDI     = 4;
    localparam int DD_SERIAL2  = 5;
    localparam int DD_SERIAL1  = 6;
    localparam int DD_PARALLEL = 7;
    localparam int DD_FIRST    = 3;
    localparam int N_BLOCKS    = 5;
    localparam logic [REG_W-1:0] DD_MASK = 8'hF9;

    // Lock pin configuration code that arms the lock
    localparam logic [1:0] LOCK_CFG_CODE = 2'b01;

    // ------------------------------------------------------------
    // Pin configuration fields
    // ------------------------------------------------------------
    localparam int PC_DIR_IN     = 0;
    localparam int PC_INVERT     = 1;
    localparam int PC_ALT_JOY    = 2;
    localparam int PC_OPEN_DRAIN = 7;
    localparam logic [REG_W-1:0] PC_MASK = 8'h87;

    // ------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_t;

endpackage : rt_regs_pkg

// >>> src/joy_pin_cell.sv
// General-purpose pin cell with polarity, direction, driver type and joystick routing
module joy_pin_cell
    import rt_regs_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Configuration
    input  wire logic [REG_W-1:0] pin_cfg,
    // Core side
    input  wire logic             gpio_out_data,
    output logic                  gpio_in_data,
    output logic                  joystick_one_button_one,
    // Pad side
    input  wire logic             pad_in,
    output logic                  pad_out,
    output logic                  pad_oe
);
    import rt_regs_pkg::*;

    logic dir_in;
    logic invert;
    logic open_drain;
    logic pad_level;
    logic drive_level;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // direction bit
    assign dir_in      = pin_cfg[PC_DIR_IN];
    assign invert      = pin_cfg[PC_INVERT];
    assign pad_level   = pad_in ^ invert;
    assign drive_level = gpio_out_data ^ invert;
    assign open_drain  = pin_cfg[PC_OPEN_DRAIN];

    // Pad driver: open drain only pulls low
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (dir_in) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (open_drain) begin
            pad_out <= 1'b0;
            pad_oe  <= ~drive_level;
        end else begin
            pad_out <= drive_level;
            pad_oe  <= 1'b1;
        end
    end

    // Inward value, steered to the joystick button or to plain use
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gpio_in_data            <= 1'b0;
            joystick_one_button_one <= 1'b0;
        end else begin
            gpio_in_data            <= pin_cfg[PC_ALT_JOY] ? 1'b0 : pad_level;
            joystick_one_button_one <= pin_cfg[PC_ALT_JOY] ? pad_level : 1'b0;
        end
    end

endmodule : joy_pin_cell

// >>> bench/runtime_disable_gpio_regs_monitor.sv
// Checker for the disable, FIFO shadow and joystick pin register slice
module runtime_disable_gpio_regs_monitor
    import rt_regs_pkg::*;
(
    // Clock, reset and bus
    input logic ref_clk, reset, psel, penable, pwrite, pready, pslverr,
    input logic [rt_regs_pkg::ADDR_W-1:0] paddr,
    input logic [rt_regs_pkg::DATA_W-1:0] pwdata, prdata,
    input logic [3:0] pstrb,
    // Shadow feed and blocks
    input logic fifo_ctrl_wr,
    input logic [rt_regs_pkg::REG_W-1:0] fifo_ctrl_data,
    input logic floppy_activate, midi_activate, serial_two_activate, serial_one_activate,
    input logic parallel_activate, floppy_enable, midi_enable, serial_two_enable,
    input logic serial_one_enable, parallel_enable,
    // Protect, lock and pin
    input logic drive_select_zero_n, drive_select_one_n, media_protect_n, forced_protect,
    input logic core_media_protect, disable_lock_pin, disable_locked,
    input logic [1:0] disable_lock_pin_cfg,
    input logic gpio_out_data, gpio_in_data, joystick_one_button_one,
    input logic pin_pad_in, pin_pad_out, pin_pad_oe
);
    // ------------------------------------------------------------
    // Helper copies of the writable registers
    // ------------------------------------------------------------
    logic [1:0]       live_q;
    logic [REG_W-1:0] dis_q, pc_q;
    logic [4:0]       act, en;
    logic             wr_ok, lock_now;
    logic             prot_x, drv_x, joy_x, pp_x, od_x;

    // Vectors and accepted writes
    assign act = {parallel_activate, serial_one_activate, serial_two_activate,
                  midi_activate, floppy_activate};
    assign en = {parallel_enable, serial_one_enable, serial_two_enable,
                 midi_enable, floppy_enable};
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign lock_now = (disable_lock_pin_cfg == LOCK_CFG_CODE) && disable_lock_pin;

    // Expected pin and protect values from the rules
    assign prot_x = (drive_select_zero_n & forced_protect) | (drive_select_one_n & forced_protect)
                    | media_protect_n | dis_q[DD_PROTECT];
    assign drv_x  = gpio_out_data ^ pc_q[PC_INVERT];
    assign joy_x  = pc_q[PC_ALT_JOY] & (pin_pad_in ^ pc_q[PC_INVERT]);
    assign pp_x   = ~pc_q[PC_DIR_IN] & ~pc_q[PC_OPEN_DRAIN];
    assign od_x   = ~pc_q[PC_DIR_IN] & pc_q[PC_OPEN_DRAIN];

    // Track register contents from accepted writes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            live_q <= 2'h0;
            dis_q  <= RST_DISABLE;
            pc_q   <= RST_PIN_CFG;
        end else begin
            live_q <= {live_q[0], 1'b1};
            if (wr_ok && !lock_now && paddr == ADDR_DISABLE) dis_q <= pwdata[7:0];
            if (wr_ok && paddr == ADDR_PIN_CFG) pc_q <= pwdata[7:0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_block_gate: assert property (live_q[1] |-> en == ($past(act) & ~$past(dis_q[7:3])))
        else $error("block enable does not follow activate and disable bits");
    a_protect_or: assert property (live_q[1] |-> core_media_protect == $past(prot_x))
        else $error("media protect equation broken");
    a_lock_status: assert property (live_q[1] |-> disable_locked == $past(lock_now))
        else $error("lock status wrong");
    a_locked_refuse: assert property (psel && penable && pwrite && paddr == ADDR_DISABLE
        && lock_now && $past(lock_now) |-> pslverr) else $error("locked write accepted");
    a_shadow_refuse: assert property (psel && penable && pwrite
        && paddr == ADDR_FIFO_SHADOW |-> pslverr) else $error("shadow write accepted");
    a_ready_access: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
        else $error("no ready in first access cycle");
    a_pin_input: assert property (live_q[1] && $past(pc_q[PC_DIR_IN]) |-> !pin_pad_oe)
        else $error("input pin driven");
    a_push_pull: assert property (live_q[1] && $past(pp_x) |-> pin_pad_oe
        && pin_pad_out == $past(drv_x)) else $error("push-pull drive wrong");
    a_open_drain: assert property (live_q[1] && $past(od_x) |-> !pin_pad_out
        && pin_pad_oe == !$past(drv_x)) else $error("open drain wrong");
    a_joy_route: assert property (live_q[1] |-> joystick_one_button_one == $past(joy_x))
        else $error("joystick route wrong");

    // Main scenarios
    c_dis_write: cover property (wr_ok && paddr == ADDR_DISABLE);
    c_error: cover property (pready && pslverr);
    c_locked: cover property (disable_locked);
    c_joy: cover property (joystick_one_button_one);
endmodule : runtime_disable_gpio_regs_monitor

bind runtime_disable_gpio_regs runtime_disable_gpio_regs_monitor runtime_disable_gpio_regs_monitor_i (.*);

// >>> bench/runtime_disable_gpio_regs_bench.sv
// Self-checking bench for the disable, FIFO shadow and joystick pin register slice
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); end end
module runtime_disable_gpio_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rt_regs_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rdat;
    logic [3:0]        pstrb = 4'hF, prot_v = 4'h0;
    logic              pready, pslverr, rerr, fifo_ctrl_wr = 0;
    logic [REG_W-1:0]  fifo_ctrl_data = '0;
    logic [4:0]        act_v = 5'h1F, en_v;
    logic floppy_activate, midi_activate, serial_two_activate, serial_one_activate;
    logic parallel_activate, floppy_enable, midi_enable, serial_two_enable;
    logic serial_one_enable, parallel_enable, core_media_protect, disable_locked;
    logic drive_select_zero_n, drive_select_one_n, media_protect_n, forced_protect;
    logic [1:0]        disable_lock_pin_cfg = 2'b00;
    logic              disable_lock_pin = 0, gpio_out_data = 0, pin_pad_in = 0;
    logic              gpio_in_data, joystick_one_button_one, pin_pad_out, pin_pad_oe;
    int                miscompares = 0, n_tests = 0;
    logic [7:0]  fifo_tab [3] = '{8'hFF, 8'h31, 8'hC9};
    // Entries: config, {data, pad}, {oe, out, gpio in, joystick}
    logic [15:0] pin_tab [9] = '{16'h0112, 16'h0310, 16'h0511, 16'h0701, 16'h002C,
                                 16'h022A, 16'h8020, 16'h8008, 16'h822A};

    assign {parallel_activate, serial_one_activate, serial_two_activate,
            midi_activate, floppy_activate} = act_v;
    assign en_v = {parallel_enable, serial_one_enable, serial_two_enable,
                   midi_enable, floppy_enable};
    assign {drive_select_zero_n, drive_select_one_n, media_protect_n, forced_protect} = prot_v;

    runtime_disable_gpio_regs runtime_disable_gpio_regs_i (.*);

    always #4 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // One APB transfer, checks error flag and read data
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                       input logic [7:0] xd, input logic xe);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 16) begin
            miscompares++;
            end_sim();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(rerr, xe)
        if (!w) `CHK(rdat, {24'h0, xd})
    endtask : apb

    // Let registered outputs follow new inputs
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        apb(0, ADDR_DISABLE, 0, 8'h00, 0);
        apb(0, ADDR_PIN_CFG, 0, 8'h01, 0);
        apb(0, 12'h090, 0, 8'h00, 1);
        // Shadow capture and refusal
        foreach (fifo_tab[i]) begin
            @(posedge ref_clk);
            fifo_ctrl_wr <= 1'b1;
            fifo_ctrl_data <= fifo_tab[i];
            @(posedge ref_clk);
            fifo_ctrl_wr <= 1'b0;
            apb(0, ADDR_FIFO_SHADOW, 0, fifo_tab[i] & 8'hCF, 0);
        end
        apb(1, ADDR_FIFO_SHADOW, 8'h00, 0, 1);
        apb(0, ADDR_FIFO_SHADOW, 0, 8'hC9, 0);
        // Block disables
        apb(1, ADDR_DISABLE, 8'hFF, 0, 0);
        apb(0, ADDR_DISABLE, 0, 8'hF9, 0);
        for (int i = 0; i < 5; i++) begin
            apb(1, ADDR_DISABLE, 8'h08 << i, 0, 0);
            settle();
            `CHK(en_v, 5'h1F & ~(5'h01 << i))
        end
        apb(1, ADDR_DISABLE, 8'h00, 0, 0);
        @(posedge ref_clk);
        act_v <= 5'h0A;
        settle();
        `CHK(en_v, 5'h0A)
        // Write protect terms
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            prot_v <= 4'(i);
            settle();
            `CHK(core_media_protect, (i[3] & i[0]) | (i[2] & i[0]) | i[1])
        end
        @(posedge ref_clk);
        prot_v <= 4'h0;
        apb(1, ADDR_DISABLE, 8'h01, 0, 0);
        settle();
        `CHK(core_media_protect, 1'b1)
        // Lock
        @(posedge ref_clk);
        disable_lock_pin_cfg <= 2'b01;
        disable_lock_pin <= 1'b1;
        settle();
        `CHK(disable_locked, 1'b1)
        apb(1, ADDR_DISABLE, 8'h80, 0, 1);
        apb(0, ADDR_DISABLE, 0, 8'h01, 0);
        @(posedge ref_clk);
        disable_lock_pin <= 1'b0;
        apb(1, ADDR_DISABLE, 8'h80, 0, 0);
        @(posedge ref_clk);
        disable_lock_pin_cfg <= 2'b10;
        disable_lock_pin <= 1'b1;
        apb(1, ADDR_DISABLE, 8'h40, 0, 0);
        apb(0, ADDR_DISABLE, 0, 8'h40, 0);
        // Pin modes
        foreach (pin_tab[i]) begin
            apb(1, ADDR_PIN_CFG, pin_tab[i][15:8], 0, 0);
            @(posedge ref_clk);
            gpio_out_data <= pin_tab[i][5];
            pin_pad_in <= pin_tab[i][4];
            settle();
            `CHK({pin_pad_oe, pin_pad_out & ~pin_tab[i][8], gpio_in_data, joystick_one_button_one}, pin_tab[i][3:0])
        end
        apb(1, ADDR_PIN_CFG, 8'hFF, 0, 0);
        apb(0, ADDR_PIN_CFG, 0, 8'h87, 0);
        // Write without lane 0 strobe leaves the register alone
        pstrb <= 4'hE;
        apb(1, ADDR_PIN_CFG, 8'h00, 0, 0);
        pstrb <= 4'hF;
        apb(0, ADDR_PIN_CFG, 0, 8'h87, 0);
        end_sim();
    end

    // Watchdog
    initial begin
        #50000;
        miscompares++;
        end_sim();
    end
endmodule : runtime_disable_gpio_regs_bench
